/* hw/pae_defines.vh */
// constants for the process alarm evaluator
`ifndef PAE_DEFINES_VH
`define PAE_DEFINES_VH
`define PAE_TYPE_W        5
`define PAE_TYPE_OFF      5'h00
`define PAE_TYPE_BAND_OUT 5'h01
`define PAE_TYPE_DEV_HI   5'h02
`define PAE_TYPE_DEV_LO   5'h03
`define PAE_TYPE_BAND_IN  5'h04
`define PAE_TYPE_BAND_SB  5'h05
`define PAE_TYPE_HI_SB    5'h06
`define PAE_TYPE_LO_SB    5'h07
`define PAE_TYPE_ABS_HI   5'h08
`define PAE_TYPE_LOOP_BREAK 5'h0c
`define PAE_TYPE_RESET    5'h02
`define PAE_PV_SYNC       3
`endif

/* hw/pae_evaluator.v */
// four-channel process alarm evaluator with control sense
`timescale 1ns/100ps
`include "pae_defines.vh"

// Overview of operation
// RL1: direct sense: mv rises with pv
// RL2: reverse sense: mv rises as pv falls
// RL3: four channels, each own type select
// RL4: type select writable only when channel assigned
// RL5: loop break type only on channel one
// RL6: with heater detect, ch1 type hidden until assigned
// RL7: type zero holds alarm off
// RL8: type 1 alarms outside sp-low..sp+high
// RL9: type 2 default: pv >= sp+x
// RL10: type 3: pv <= sp-x
// RL11: type 4 alarms inside band
// RL12: types 5,6,7 are 1,2,3 with standby
// RL13: type 7 is lower deviation with standby
// RL14: standby suppresses until condition first clears
// RL15: type 8: pv > x absolute
// RL16: band types keep separate high/low limits
module pae_evaluator #(
   parameter W = 16                                  // signed data width
) (
   input  wire                  mclk,
   input  wire                  sys_rst,
   input  wire signed [W-1:0]   pv,                  // process value, same domain
   input  wire signed [W-1:0]   sp,                  // set point
   input  wire signed [W-1:0]   mv_in,               // manipulated variable from pid
   input  wire                  control_sense_select, // 1 = direct, 0 = reverse
   input  wire [3:0]            out_assigned,        // channel has an output
   input  wire                  heater_burnout_short_detect, // detection fitted
   input  wire [3:0]            type_wr,             // per-channel type write strobe
   input  wire [`PAE_TYPE_W-1:0] type_wdata,         // type code to write
   input  wire [4*W-1:0]        alarm_val,           // x per channel
   input  wire [4*W-1:0]        alarm_hi,            // high deviation per channel
   input  wire [4*W-1:0]        alarm_lo,            // low deviation per channel
   input  wire                  standby_restart,     // re-arm standby sequence
   output reg  signed [W-1:0]   mv_out,              // sense-corrected mv
   output reg  [3:0]            alarm_out,           // alarm per channel
   output wire [3:0]            type_visible,        // type select shown
   output wire [4*`PAE_TYPE_W-1:0] type_rd,          // current type codes
   output reg  [3:0]            type_reject          // pulses one clock after a refused write
);

   // stored state: the type codes and the standby release flags
   reg  [`PAE_TYPE_W-1:0] type_q [0:3];              // type code per channel
   reg  [3:0]             armed_q;                   // standby released per channel

   // next-state values, all built combinationally
   reg  [3:0]             armed_d;                   // next standby release state
   reg  [3:0]             alarm_d;                   // next alarm output levels
   reg  [3:0]             reject_d;                  // next refusal pulses
   reg  [3:0]             accept;                    // write taken this cycle
   reg  signed [W-1:0]    mv_d;                      // next sense-corrected mv

   // comparison results, all combinational
   reg  [3:0]             raw;                       // condition met, before standby
   reg  [3:0]             sb_type;                   // channel runs a standby type

   // visibility helper for the first channel
   wire                   ch1_hidden;                // ch1 type select hidden

   // loop indices, one per process so no variable has two drivers
   integer                i;                         // type register process
   integer                j;                         // comparison process
   integer                k;                         // next-state process

   // raw comparison for one type code
   // the band limits are kept two bits wider than the data so that
   // a set point near full scale plus a deviation cannot wrap round
   // and turn an alarm off where it should be on
   function cmp;
      input [`PAE_TYPE_W-1:0] t;                     // type code of the channel
      input signed [W-1:0]    p;                     // process value
      input signed [W-1:0]    s;                     // set point
      input signed [W-1:0]    x;                     // single alarm value
      input signed [W-1:0]    h;                     // high deviation
      input signed [W-1:0]    l;                     // low deviation
      reg signed [W+1:0]      pe;                    // widened process value
      reg signed [W+1:0]      hi_lim;                // set point plus high deviation
      reg signed [W+1:0]      lo_lim;                // set point minus low deviation
      begin
         pe     = p;
         hi_lim = s + h;
         lo_lim = s - l;
         case (t)
            // outside the band: upper or lower excursion
            `PAE_TYPE_BAND_OUT, `PAE_TYPE_BAND_SB:
               cmp = (pe > hi_lim) || (pe < lo_lim);           // RL8 RL16
            // upper deviation, boundary included
            `PAE_TYPE_DEV_HI, `PAE_TYPE_HI_SB:
               cmp = (pe >= ($signed({s[W-1],s[W-1],s}) + x)); // RL9
            // lower deviation, boundary included
            `PAE_TYPE_DEV_LO, `PAE_TYPE_LO_SB:
               cmp = (pe <= ($signed({s[W-1],s[W-1],s}) - x)); // RL10 RL13
            // inside the band, both edges included
            `PAE_TYPE_BAND_IN:
               cmp = (pe <= hi_lim) && (pe >= lo_lim);         // RL11 RL16
            // absolute upper limit, set point ignored
            `PAE_TYPE_ABS_HI:
               cmp = (p > x);                                  // RL15
            // off, loop break and unmodelled codes stay quiet
            default:
               cmp = 1'b0;                                     // RL7
         endcase
      end
   endfunction

   // standby classification of a type code
   function is_standby;
      input [`PAE_TYPE_W-1:0] t;                     // type code of the channel
      begin
         case (t)
            `PAE_TYPE_BAND_SB,
            `PAE_TYPE_HI_SB,
            `PAE_TYPE_LO_SB:
               is_standby = 1'b1;                              // RL12 RL13
            default:
               is_standby = 1'b0;                              // plain types
         endcase
      end
   endfunction

   // write refusal for one channel
   // a refused write leaves the stored code and the standby state alone
   function refused;
      input [`PAE_TYPE_W-1:0] t;                     // requested code
      input                   assigned;              // channel has an output
      input                   first_ch;              // this is channel one
      begin
         if (!assigned) begin
            refused = 1'b1;                                    // RL4
         end else if (t > `PAE_TYPE_LOOP_BREAK) begin
            refused = 1'b1;                                    // codes past loop break unsupported
         end else if ((t == `PAE_TYPE_LOOP_BREAK) && !first_ch) begin
            refused = 1'b1;                                    // RL5
         end else begin
            refused = 1'b0;                                    // write taken
         end
      end
   endfunction

   // ch1 hides its type select under heater detect until assigned
   // the unassigned rule already hides it, so this only documents intent
   assign ch1_hidden      = heater_burnout_short_detect & ~out_assigned[0]; // RL6
   assign type_visible[0] = out_assigned[0] & ~ch1_hidden;    // RL4 RL6
   assign type_visible[1] = out_assigned[1];                  // RL4
   assign type_visible[2] = out_assigned[2];                  // RL4
   assign type_visible[3] = out_assigned[3];                  // RL4

   // read-back of the stored type codes, straight from the flip-flops
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_rd
         assign type_rd[g*`PAE_TYPE_W +: `PAE_TYPE_W] = type_q[g]; // RL3
      end
   endgenerate

   // combinational compare and standby classification per channel
   always @* begin
      raw     = 4'h0;
      sb_type = 4'h0;
      for (j = 0; j < 4; j = j + 1) begin
         // each channel sees its own limits and its own type
         raw[j] = cmp(type_q[j], pv, sp,
                      alarm_val[j*W +: W], alarm_hi[j*W +: W], alarm_lo[j*W +: W]); // RL3
         sb_type[j] = is_standby(type_q[j]);                   // RL12
      end
   end

   // next-state logic for writes, standby arming and alarms
   // a taken write restarts standby so a new standby type never alarms at once
   always @* begin
      armed_d  = armed_q;
      alarm_d  = 4'h0;
      reject_d = 4'h0;
      accept   = 4'h0;
      for (k = 0; k < 4; k = k + 1) begin
         if (type_wr[k]) begin
            // write strobe: either take it or pulse the refusal
            if (refused(type_wdata, out_assigned[k], (k == 0))) begin
               reject_d[k] = 1'b1;                             // RL4 RL5
            end else begin
               accept[k]  = 1'b1;                              // RL3
               armed_d[k] = 1'b0;                              // new type restarts standby
            end
         end else if (standby_restart) begin
            armed_d[k] = 1'b0;                                 // RL14
         end else if (!raw[k]) begin
            armed_d[k] = 1'b1;                                 // RL14
         end
         // loop break internals not modelled; it stays quiet here
         alarm_d[k] = raw[k] && (!sb_type[k] || armed_q[k]);   // RL7 RL14
      end
   end

   // sense selection for the manipulated variable
   // negation of the most negative value wraps; limited range is left to the user
   always @* begin
      if (control_sense_select) begin
         mv_d = mv_in;                                         // RL1
      end else begin
         mv_d = -mv_in;                                        // RL2
      end
   end

   // type registers: reset default, then only taken writes land
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (i = 0; i < 4; i = i + 1) begin
            type_q[i] <= `PAE_TYPE_RESET;                      // RL9
         end
      end else begin
         for (i = 0; i < 4; i = i + 1) begin
            if (accept[i]) begin
               type_q[i] <= type_wdata;                        // RL3
            end
         end
      end
   end

   // standby flags, alarm outputs and refusal pulses
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         armed_q     <= 4'h0;                                  // standby held after start-up
         alarm_out   <= 4'h0;                                  // no alarm in reset
         type_reject <= 4'h0;                                  // no refusal in reset
      end else begin
         armed_q     <= armed_d;                               // RL14
         alarm_out   <= alarm_d;                               // RL7
         type_reject <= reject_d;                              // RL4 RL5
      end
   end

   // control sense: reverse inverts mv direction against pv
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mv_out <= {W{1'b0}};                                  // quiet drive in reset
      end else begin
         mv_out <= mv_d;                                       // RL1 RL2
      end
   end

endmodule // pae_evaluator

/* verif/pae_plant.sv */
// plant model: measured value follows the applied drive one clock later
`timescale 1ns/100ps
module pae_plant (
   input  wire               mclk,
   input  wire [15:0]        step,
   output reg  signed [15:0] pv = 16'sh0000
);
   // nine-bit drive keeps sums with the set point inside sixteen bits
   always @(posedge mclk) pv <= $signed(step[8:0]);
endmodule // pae_plant

/* verif/pae_evaluator_asserts.sv */
// port assertions for the alarm evaluator
`timescale 1ns/100ps
`include "pae_defines.vh"
module pae_chk #(
   parameter W = 16
) (
   input wire                mclk,
   input wire                sys_rst,
   input wire                control_sense_select,
   input wire signed [W-1:0] mv_in,
   input wire signed [W-1:0] mv_out,
   input wire [4:0]          type_wdata,
   input wire [19:0]         type_rd,
   input wire [3:0]          out_assigned,
   input wire [3:0]          type_wr,
   input wire [3:0]          alarm_out,
   input wire [3:0]          type_visible,
   input wire [3:0]          type_reject
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // loop break request on the first channel with an output behind it
   sequence lba_one; type_wr[0] && out_assigned[0] && type_wdata == `PAE_TYPE_LOOP_BREAK; endsequence
   chk_mv_direct: assert property (control_sense_select |=> mv_out == $past(mv_in)) else $error("mv");
   chk_mv_reverse: assert property (!control_sense_select |=> mv_out == -$past(mv_in)) else $error("mv");
   chk_unasg_wr: assert property (type_wr[2] && !out_assigned[2] |=> type_reject[2]) else $error("wr");
   chk_lba_other: assert property (type_wr[1] && type_wdata == `PAE_TYPE_LOOP_BREAK |=> type_reject[1]) else $error("l");
   chk_lba_one: assert property (lba_one |=> type_rd[4:0] == `PAE_TYPE_LOOP_BREAK) else $error("l");
   chk_off_quiet: assert property (type_rd[4:0] == `PAE_TYPE_OFF |=> !alarm_out[0]) else $error("off");
   chk_vis_asg: assert property (type_visible == out_assigned) else $error("vis");
   chk_ch_indep: assert property (type_wr[3] && out_assigned[3] && type_wdata < `PAE_TYPE_LOOP_BREAK
      |=> type_rd[19:15] == $past(type_wdata)) else $error("ch");
endmodule // pae_chk
bind pae_evaluator pae_chk #(.W(W)) pae_chk_i (
   .mclk(mclk),
   .sys_rst(sys_rst),
   .control_sense_select(control_sense_select),
   .mv_in(mv_in),
   .mv_out(mv_out),
   .type_wdata(type_wdata),
   .type_rd(type_rd),
   .out_assigned(out_assigned),
   .type_wr(type_wr),
   .alarm_out(alarm_out),
   .type_visible(type_visible),
   .type_reject(type_reject)
);

/* verif/pae_evaluator_tb_top.sv */
// random self-checking bench for the alarm evaluator
`timescale 1ns/100ps
module pae_evaluator_tb_top;
   reg mclk = 0, sys_rst = 1, control_sense_select = 0, standby_restart = 0, heater_burnout_short_detect = 0;
   reg signed [15:0] sp = 0, mv_in = 0, step = 0, em = 0;
   reg [3:0]  out_assigned = 0, type_wr = 0, arm = 0, ea = 0, ej = 0;
   reg [4:0]  type_wdata = 0;
   reg [63:0] alarm_val = 0, alarm_hi = 0, alarm_lo = 0;
   wire signed [15:0] pv, mv_out;
   wire [3:0] alarm_out, type_visible, type_reject;
   wire [19:0] type_rd;
   integer n_errors = 0, samples_checked = 0, i, c, t, r, x, h, l, typ [4] = '{2, 2, 2, 2};
   initial forever #2.5 mclk = ~mclk;
   pae_plant pae_plant_i (.mclk(mclk), .step(step), .pv(pv));
   pae_evaluator pae_evaluator_i (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pv(pv),
      .sp(sp),
      .mv_in(mv_in),
      .control_sense_select(control_sense_select),
      .out_assigned(out_assigned),
      .heater_burnout_short_detect(heater_burnout_short_detect),
      .type_wr(type_wr),
      .type_wdata(type_wdata),
      .alarm_val(alarm_val),
      .alarm_hi(alarm_hi),
      .alarm_lo(alarm_lo),
      .standby_restart(standby_restart),
      .mv_out(mv_out),
      .alarm_out(alarm_out),
      .type_visible(type_visible),
      .type_rd(type_rd),
      .type_reject(type_reject)
   );
   task check(input [31:0] seen, input [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) n_errors = n_errors + 1;
      if (seen !== exp) $display("CHECK FAILED %0t: %h not %h", $time, seen, exp);
   endtask
   task complete_run;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog, twice the expected run
   initial begin
      #40000 n_errors = n_errors + 1;
      complete_run;
   end
   // model sees the inputs at the falling edge, one clock ahead of the outputs
   initial begin
      r = $urandom(32'h562ecc7c);
      repeat (12) @(posedge mclk);
      sys_rst <= 0;
      for (c = 0; c < 4000; c = c + 1) begin
         @(negedge mclk) check({alarm_out, type_reject}, {ea, ej});
         check(mv_out, em);
         check(type_rd, {typ[3][4:0], typ[2][4:0], typ[1][4:0], typ[0][4:0]});
         check(type_visible, out_assigned);
         em = control_sense_select ? mv_in : -mv_in;
         for (i = 0; i < 4; i = i + 1) begin
            x = alarm_val[i*16+:16];
            h = sp + alarm_hi[i*16+:16];
            l = sp - alarm_lo[i*16+:16];
            t = typ[i] > 4 && typ[i] < 8 ? typ[i] - 4 : typ[i];
            r = t == 1 ? pv > h || pv < l : t == 2 ? pv >= sp + x : t == 3 ? pv <= sp - x : t == 4 ? pv >= l && pv <= h
               : t == 8 && pv > x;
            ea[i] = r && (t == typ[i] || arm[i]);
            ej[i] = type_wr[i] && !(out_assigned[i] && type_wdata <= 12 && (type_wdata != 12 || i == 0));
            // a refused write leaves the standby state as it was
            arm[i] = type_wr[i] ? arm[i] && ej[i] : !standby_restart && (arm[i] || !r);
            if (type_wr[i] && !ej[i]) typ[i] = type_wdata;
         end
         @(posedge mclk) {control_sense_select, heater_burnout_short_detect, out_assigned, type_wdata, step} <= $urandom;
         {standby_restart, type_wr} <= $urandom & $urandom & $urandom;
         {sp, mv_in} <= $urandom & 32'h00ffffff;
         alarm_val <= {$urandom, $urandom} & {4{16'h00ff}};
         {alarm_hi, alarm_lo} <= {$urandom, $urandom, $urandom, $urandom} & {8{16'h00ff}};
      end
      complete_run;
   end
endmodule // pae_evaluator_tb_top
